// [rtl/dcf_cfg.svh]
// offsets, widths and reset values for the dual-clock fifo flag block
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
`define DCF_DW 18
`define DCF_AW 11
`define DCF_PW 12
`define DCF_DEPTH 12'h0800
`define DCF_OFFW 11
`define DCF_SERW 22
`define DCF_PAE_LSB 0
`define DCF_PAF_LSB 11
`define DCF_PAE_RST 11'h07f
`define DCF_PAF_RST 11'h07f
`define DCF_BUF_DEPTH 2'h2
`endif

// [rtl/dcf_fifo.sv]
// dual-clock fifo core: flags, fall-through read, mark and retransmit, offset programming
// What the document requires of this block and of its reader
// RULE_01: input ready returns one write tick after a read, one more if ticks coincide.
// RULE_02: almost full releases one write tick after a read, one more if coincident.
// RULE_03: reader holds read enable high one read tick after read select falls.
// RULE_04: read enable low with or before select drops the first fall-through word.
// RULE_05: first word falls through alone; later reads need enable and select low.
// RULE_06: once marked, writes stop at the marked location.
// RULE_07: controller keeps 32, 64 or 128 bytes between pointers before marking.
// RULE_08: almost empty may change one read tick early during retransmit setup.
// RULE_09: standard mode shows retransmit setup done by empty flag returning high.
// RULE_10: reader keeps retransmit request high during normal reads.
// RULE_11: serial offset load uses X bits per offset; here X is 11.
// RULE_12: a parallel offset load replaces the old offset entirely.
// RULE_13: reader leaves one idle read tick between offset register reads.
// RULE_14: flag timing select high at reset makes almost full update on write ticks.
// RULE_15: synchronous almost empty releases one read tick after a write, one more if coincident.
// RULE_16: almost-full depth reference is one word larger in fall-through mode.
// RULE_17: flag timing select low at reset gives asynchronous almost flags.
// RULE_18: asynchronous almost full sets on write ticks and clears on read ticks.
// RULE_19: each pointer crosses through a snapshot register stage into the other side.
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wclk_en,
    input wire logic rclk_en,
    input wire logic fall_through_mode,
    input wire logic flag_timing_select,
    input wire logic [`DCF_DW-1:0] din,
    input wire logic din_valid,
    output logic din_ready,
    input wire logic ld_n,
    input wire logic ser_en,
    input wire logic ser_in,
    input wire logic ren_n,
    input wire logic read_select_n,
    input wire logic mark,
    input wire logic retransmit_req_n,
    output logic [`DCF_DW-1:0] dout,
    output logic q_out_en_n,
    output logic input_ready_flag,
    output logic empty_flag_n,
    output logic almost_full_flag,
    output logic almost_empty_flag
);
    // ==========================================================
    // configuration latched at master reset
    logic fall_through_mode_r;
    logic sync_flags_r;
    logic [`DCF_SERW-1:0] offs_r;
    logic ld_wsel_r;
    logic ld_rsel_r;
    dcf_pkg::dcf_word_t mem_r [0:`DCF_DEPTH-1];
    dcf_pkg::dcf_word_t buf_r [0:1];
    logic buf_head_r;
    logic [1:0] buf_cnt_r;
    dcf_pkg::dcf_ptr_t wptr_r, wptr_snap_r, wptr_rd_r;
    dcf_pkg::dcf_ptr_t rptr_r, mark_ptr_r, rlim_snap_r, rlim_w_r;
    logic ovalid_r, ovalid_snap_r, ovalid_w_r;
    logic mark_r;
    logic paf_async_r, pae_async_r;
    logic oe_r;
    dcf_pkg::dcf_word_t dout_r;
    dcf_pkg::dcf_rt_state_e rt_state_r;
    dcf_pkg::dcf_ptr_t mem_w, fill_w, depth_max, mem_r_cnt, fill_r, rlim_now;
    logic [`DCF_OFFW-1:0] pae_off, paf_off;
    logic full_w, wr_go, push, paf_cond_w, pae_cond_w, paf_cond_r, pae_cond_r;
    logic rd_en, rt_go, ld_read;

    // mode pins caught while reset is held
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fall_through_mode_r <= fall_through_mode;
            sync_flags_r <= flag_timing_select; // [RULE_14] [RULE_17]
        end
    end

    // ==========================================================
    // write side view of the fifo
    assign pae_off = offs_r[`DCF_PAE_LSB +: `DCF_OFFW];
    assign paf_off = offs_r[`DCF_PAF_LSB +: `DCF_OFFW];
    assign depth_max = `DCF_DEPTH + {11'h000, fall_through_mode_r}; // [RULE_16]
    assign mem_w = wptr_r - rlim_w_r;
    assign fill_w = mem_w + {11'h000, ovalid_w_r & fall_through_mode_r};
    // mark holds the limit so retained data is never overwritten
    assign full_w = (mem_w >= `DCF_DEPTH) || (fill_w >= depth_max); // [RULE_06]
    assign paf_cond_w = fill_w >= (depth_max - {1'b0, paf_off});
    assign pae_cond_w = fill_w <= {1'b0, pae_off};
    assign wr_go = wclk_en && (buf_cnt_r != 2'h0) && !full_w && ld_n;
    assign push = din_valid && din_ready && ld_n;
    assign din_ready = ld_n ? (buf_cnt_r != `DCF_BUF_DEPTH) : wclk_en;
    assign input_ready_flag = !full_w; // [RULE_01]

    // two-entry input buffer, drained by write ticks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            buf_head_r <= 1'b0;
            buf_cnt_r <= 2'h0;
        end else begin
            if (push) begin
                buf_r[buf_head_r ^ buf_cnt_r[0]] <= din;
            end
            if (wr_go) begin
                buf_head_r <= !buf_head_r;
            end
            buf_cnt_r <= buf_cnt_r + {1'b0, push} - {1'b0, wr_go};
        end
    end

    // memory write and write pointer with its snapshot for the read side
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wptr_r <= 12'h000;
            wptr_snap_r <= 12'h000;
        end else if (wr_go) begin
            mem_r[wptr_r[`DCF_AW-1:0]] <= buf_r[buf_head_r];
            wptr_r <= wptr_r + 12'h001;
            wptr_snap_r <= wptr_r + 12'h001; // [RULE_19]
        end
    end

    // read side state seen on write ticks; a read on the same tick lands one tick later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rlim_w_r <= 12'h000;
            ovalid_w_r <= 1'b0;
        end else if (wclk_en) begin
            rlim_w_r <= rlim_snap_r; // [RULE_01] [RULE_02] [RULE_19]
            ovalid_w_r <= ovalid_snap_r;
        end
    end

    // offset registers: parallel load beats serial shift
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            offs_r <= {`DCF_PAF_RST, `DCF_PAE_RST};
            ld_wsel_r <= 1'b0;
        end else if (wclk_en && !ld_n && din_valid) begin
            if (ld_wsel_r) begin
                offs_r[`DCF_PAF_LSB +: `DCF_OFFW] <= din[`DCF_OFFW-1:0]; // [RULE_12]
            end else begin
                offs_r[`DCF_PAE_LSB +: `DCF_OFFW] <= din[`DCF_OFFW-1:0]; // [RULE_12]
            end
            ld_wsel_r <= !ld_wsel_r;
        end else if (wclk_en && ser_en) begin
            offs_r <= {ser_in, offs_r[`DCF_SERW-1:1]}; // [RULE_11]
        end
    end

    // ==========================================================
    // read side view of the fifo
    assign rlim_now = mark_r ? mark_ptr_r : rptr_r;
    assign mem_r_cnt = wptr_rd_r - rptr_r;
    assign fill_r = (wptr_rd_r - rlim_now) + {11'h000, ovalid_r & fall_through_mode_r};
    assign paf_cond_r = fill_r >= (depth_max - {1'b0, paf_off});
    assign pae_cond_r = fill_r <= {1'b0, pae_off};
    assign rd_en = !ren_n && !read_select_n;
    assign rt_go = rclk_en && !retransmit_req_n && mark_r && (rt_state_r == dcf_pkg::DCF_RT_IDLE); // [RULE_10]
    assign ld_read = rclk_en && !ld_n && rd_en && (rt_state_r == dcf_pkg::DCF_RT_IDLE); // [RULE_13]

    // write pointer arrives on read ticks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wptr_rd_r <= 12'h000;
        end else if (rclk_en) begin
            wptr_rd_r <= wptr_snap_r; // [RULE_15] [RULE_19]
        end
    end

    // mark capture follows the mark input on read ticks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mark_r <= 1'b0;
            mark_ptr_r <= 12'h000;
        end else if (rclk_en) begin
            if (mark && !mark_r) begin
                mark_ptr_r <= rptr_r; // [RULE_06]
            end
            mark_r <= mark;
        end
    end

    // retransmit setup sequence; reads are held off until idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rt_state_r <= dcf_pkg::DCF_RT_IDLE;
        end else if (rclk_en) begin
            case (rt_state_r)
                dcf_pkg::DCF_RT_IDLE: begin
                    if (rt_go) begin
                        rt_state_r <= dcf_pkg::DCF_RT_SETUP1;
                    end
                end
                dcf_pkg::DCF_RT_SETUP1: begin
                    rt_state_r <= dcf_pkg::DCF_RT_SETUP2;
                end
                dcf_pkg::DCF_RT_SETUP2: begin
                    rt_state_r <= dcf_pkg::DCF_RT_IDLE; // [RULE_09]
                end
                default: begin
                    rt_state_r <= dcf_pkg::DCF_RT_IDLE;
                end
            endcase
        end
    end

    // read pointer, output register and offset readback
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rptr_r <= 12'h000;
            ovalid_r <= 1'b0;
            dout_r <= 18'h0_0000;
            ld_rsel_r <= 1'b0;
        end else if (rclk_en) begin
            if (rt_go) begin
                rptr_r <= mark_ptr_r;
                ovalid_r <= 1'b0;
            end else if (ld_read) begin
                dout_r <= {7'h00, ld_rsel_r ? paf_off : pae_off};
                ld_rsel_r <= !ld_rsel_r;
            end else if (rt_state_r == dcf_pkg::DCF_RT_IDLE) begin
                if (!fall_through_mode_r) begin
                    if (rd_en && mem_r_cnt != 12'h000) begin
                        dout_r <= mem_r[rptr_r[`DCF_AW-1:0]];
                        rptr_r <= rptr_r + 12'h001;
                    end
                end else if ((!ovalid_r || rd_en) && mem_r_cnt != 12'h000) begin
                    // an enabled read at the select edge consumes the fallen-through word
                    dout_r <= mem_r[rptr_r[`DCF_AW-1:0]]; // [RULE_05] [RULE_04]
                    rptr_r <= rptr_r + 12'h001;
                    ovalid_r <= 1'b1;
                end else if (rd_en) begin
                    ovalid_r <= 1'b0; // [RULE_05]
                end
            end
        end
    end

    // read side state offered to the write side one cycle after it settles, so a write tick one cycle after a read still sees the old state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rlim_snap_r <= 12'h000;
            ovalid_snap_r <= 1'b0;
        end else begin
            rlim_snap_r <= rlim_now; // [RULE_19] [RULE_01]
            ovalid_snap_r <= ovalid_r;
        end
    end

    // output bus drive follows read select on read ticks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            oe_r <= 1'b0;
        end else if (rclk_en) begin
            oe_r <= !read_select_n; // [RULE_04]
        end
    end

    // ==========================================================
    // asynchronous-mode almost flags: the setting edge wins over the clearing one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            paf_async_r <= 1'b0;
            pae_async_r <= 1'b1;
        end else begin
            if (wclk_en && paf_cond_w) begin
                paf_async_r <= 1'b1; // [RULE_18]
            end else if (rclk_en && !paf_cond_r) begin
                paf_async_r <= 1'b0; // [RULE_18]
            end
            if (rclk_en && pae_cond_r) begin
                pae_async_r <= 1'b1;
            end else if (wclk_en && !pae_cond_w) begin
                pae_async_r <= 1'b0;
            end
        end
    end

    // flag outputs; synchronous variants move with their own side's registers, and almost empty also with offsets loaded on write ticks
    assign almost_full_flag = sync_flags_r ? paf_cond_w : paf_async_r; // [RULE_02] [RULE_14]
    assign almost_empty_flag = sync_flags_r ? pae_cond_r : pae_async_r; // [RULE_15] [RULE_08]
    assign empty_flag_n = (rt_state_r == dcf_pkg::DCF_RT_IDLE) &&
        (fall_through_mode_r ? ovalid_r : (mem_r_cnt != 12'h000)); // [RULE_09]
    assign dout = dout_r;
    assign q_out_en_n = !oe_r;
endmodule

// [rtl/dcf_pkg.sv]
// types shared by the dual-clock fifo flag block
`include "dcf_cfg.svh"
package dcf_pkg;
    typedef logic [`DCF_PW-1:0] dcf_ptr_t;
    typedef logic [`DCF_DW-1:0] dcf_word_t;
    typedef enum logic [2:0] {
        DCF_RT_IDLE = 3'b001,
        DCF_RT_SETUP1 = 3'b010,
        DCF_RT_SETUP2 = 3'b100
    } dcf_rt_state_e;
endpackage

// [sim/dcf_fifo_chk.sv]
// port checker for the dual-clock fifo flag block
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wclk_en,
    input wire logic rclk_en,
    input wire logic flag_timing_select,
    input wire logic read_select_n,
    input wire logic [`DCF_DW-1:0] dout,
    input wire logic q_out_en_n,
    input wire logic input_ready_flag,
    input wire logic empty_flag_n,
    input wire logic almost_full_flag,
    input wire logic almost_empty_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic sync_r;
    // ==========
    // flag timing mode as latched at master reset
    always_ff @(posedge sys_clk) if (rst) sync_r <= flag_timing_select;
    bus_enable_a: assert property (rclk_en |=> q_out_en_n == $past(read_select_n))
        else $error("bus enable wrong");
    ready_rise_a: assert property ($rose(input_ready_flag) |-> $past(wclk_en))
        else $error("input ready rose off a write tick");
    data_avail_a: assert property ($rose(empty_flag_n) |-> $past(rclk_en))
        else $error("empty flag rose off a read tick");
    out_word_a: assert property ($changed(dout) |-> $past(rclk_en))
        else $error("output word moved off a read tick");
    full_sync_a: assert property (sync_r && $changed(almost_full_flag) |-> $past(wclk_en))
        else $error("sync almost full moved off a write tick");
    full_set_a: assert property (!sync_r && $rose(almost_full_flag) |-> $past(wclk_en))
        else $error("async almost full set off a write tick");
    full_clear_a: assert property (!sync_r && $fell(almost_full_flag) |-> $past(rclk_en))
        else $error("async almost full cleared off a read tick");
    aempty_sync_a: assert property (sync_r && $changed(almost_empty_flag) |-> $past(rclk_en))
        else $error("sync almost empty moved off a read tick");
endmodule
bind dcf_fifo dcf_fifo_chk u_chk (.sys_clk, .rst, .wclk_en, .rclk_en, .flag_timing_select, .read_select_n, .dout,
    .q_out_en_n, .input_ready_flag, .empty_flag_n, .almost_full_flag, .almost_empty_flag);

// [sim/dcf_fifo_tb_top.sv]
// self-checking bench for the dual-clock fifo flag block
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo_tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, ft = 1'b0, fts = 1'b0, din_valid = 1'b0, ld_n = 1'b1;
    logic ser_en = 1'b0, ser_in = 1'b0, ren_n = 1'b1, read_select_n = 1'b1, mark = 1'b0, rt_n = 1'b1;
    logic [`DCF_DW-1:0] din = 18'h0_0000;
    logic [`DCF_DW-1:0] dout;
    logic wclk_en, rclk_en, din_ready, q_out_en_n, input_ready_flag, empty_flag_n, almost_full_flag, almost_empty_flag;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    dcf_ticks #(.WP(3), .RP(5)) u_ticks (.sys_clk, .wclk_en, .rclk_en);
    dcf_fifo DUT (.sys_clk, .rst, .wclk_en, .rclk_en, .fall_through_mode(ft), .flag_timing_select(fts), .din,
        .din_valid, .din_ready, .ld_n, .ser_en, .ser_in, .ren_n, .read_select_n, .mark, .retransmit_req_n(rt_n),
        .dout, .q_out_en_n, .input_ready_flag, .empty_flag_n, .almost_full_flag, .almost_empty_flag);
    // ==========
    // compare, verdict and hang guard
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end
    // ==========
    // access tasks; each starts and ends on a rising edge
    task automatic tick(input logic r);
        @(negedge sys_clk);
        while (!(r ? rclk_en : wclk_en)) @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    task automatic do_reset(input logic f, input logic s);
        rst <= 1'b1;
        ft <= f;
        fts <= s;
        mark <= 1'b0;
        read_select_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check("reset flags", {13'h0000, q_out_en_n, input_ready_flag, empty_flag_n, almost_full_flag,
            almost_empty_flag}, 18'h0_0019);
        check("reset dout", dout, 18'h0_0000);
        @(posedge sys_clk);
    endtask
    task automatic wr_n(input logic [17:0] base, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            din <= base + 18'(i);
            din_valid <= 1'b1;
            @(negedge sys_clk);
            while (!din_ready) @(negedge sys_clk);
            @(posedge sys_clk);
        end
        din_valid <= 1'b0;
    endtask
    task automatic rd(input logic nd, input logic [17:0] exp);
        ren_n <= 1'b0;
        read_select_n <= 1'b0;
        @(negedge sys_clk);
        while (!(rclk_en && (empty_flag_n || !nd))) @(negedge sys_clk);
        @(posedge sys_clk);
        ren_n <= 1'b1;
        @(negedge sys_clk);
        check("dout", dout, exp);
        @(posedge sys_clk);
    endtask
    task automatic ser_load(input logic [21:0] v);
        for (int i = 0; i < 22; i++) begin
            ser_in <= v[i];
            ser_en <= 1'b1;
            tick(1'b0);
        end
        ser_en <= 1'b0;
    endtask
    task automatic flags(input logic [1:0] e);
        repeat (6) tick(1'b0);
        @(negedge sys_clk);
        check("almost flags", {16'h0000, almost_full_flag, almost_empty_flag}, {16'h0000, e});
        @(posedge sys_clk);
    endtask
    // ==========
    // test sequence
    initial begin
        // offsets, readback and flag thresholds in both almost-flag modes
        for (int s = 0; s < 2; s++) begin
            do_reset(1'b0, s[0]);
            ser_load({11'h7ff, 11'h002});
            ld_n <= 1'b0;
            rd(1'b0, 18'h0_0002);
            tick(1'b1);
            rd(1'b0, 18'h0_07ff);
            ld_n <= 1'b1;
            wr_n(18'h0_0400, 3);
            flags(2'b10);
            for (int i = 0; i < 3; i++) rd(1'b1, 18'h0_0400 + 18'(i));
            flags(2'b01);
            ld_n <= 1'b0;
            wr_n(18'h0_0004, 2);
            tick(1'b1);
            rd(1'b0, 18'h0_0004);
            tick(1'b1);
            rd(1'b0, 18'h0_0005);
            ld_n <= 1'b1;
        end
        // fall-through depth reference and first-word start-up
        do_reset(1'b1, 1'b1);
        ser_load({11'h7ff, 11'h002});
        wr_n(18'h0_0500, 1);
        flags(2'b01);
        wr_n(18'h0_0501, 2);
        flags(2'b10);
        read_select_n <= 1'b0;
        tick(1'b1);
        @(negedge sys_clk);
        check("fall through", dout, 18'h0_0500);
        check("bus on", {17'h0_0000, q_out_en_n}, 18'h0_0000);
        @(posedge sys_clk);
        rd(1'b1, 18'h0_0501);
        // enable falling with select loses the first word
        do_reset(1'b1, 1'b0);
        wr_n(18'h0_0600, 3);
        flags(2'b01);
        rd(1'b1, 18'h0_0601);
        // mark, read ahead, retransmit from the mark
        do_reset(1'b0, 1'b0);
        wr_n(18'h0_0300, 20);
        flags(2'b01);
        mark <= 1'b1;
        tick(1'b1);
        rd(1'b1, 18'h0_0300);
        rd(1'b1, 18'h0_0301);
        rt_n <= 1'b0;
        tick(1'b1);
        rt_n <= 1'b1;
        @(negedge sys_clk);
        check("setup", {17'h0_0000, empty_flag_n}, 18'h0_0000);
        n = 0;
        while (!empty_flag_n && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check("setup done", {17'h0_0000, empty_flag_n}, 18'h0_0001);
        @(posedge sys_clk);
        rd(1'b1, 18'h0_0300);
        // fill to the mark; marked words survive, and freed room shows on the next write tick
        wr_n(18'h0_1000, 2028);
        rd(1'b1, 18'h0_0301);
        repeat (3) tick(1'b0);
        @(negedge sys_clk);
        check("held at mark", {17'h0_0000, input_ready_flag}, 18'h0_0000);
        @(posedge sys_clk);
        mark <= 1'b0;
        tick(1'b1);
        @(negedge sys_clk);
        check("ready held", {17'h0_0000, input_ready_flag}, 18'h0_0000);
        tick(1'b0);
        @(negedge sys_clk);
        check("ready back", {17'h0_0000, input_ready_flag}, 18'h0_0001);
        @(posedge sys_clk);
        wr_n(18'h0_1800, 2);
        repeat (3) tick(1'b0);
        rd(1'b1, 18'h0_0302);
        @(negedge sys_clk);
        check("full at read", {17'h0_0000, input_ready_flag}, 18'h0_0000);
        tick(1'b0);
        @(negedge sys_clk);
        check("ready after read", {17'h0_0000, input_ready_flag}, 18'h0_0001);
        @(posedge sys_clk);
        finish_test();
    end
endmodule

// [sim/dcf_ticks.sv]
// writer and reader tick source for the dual-clock fifo bench
`timescale 1ns/1ps
module dcf_ticks #(
    parameter int WP = 3,
    parameter int RP = 5
) (
    input wire logic sys_clk,
    output logic wclk_en = 1'b0,
    output logic rclk_en = 1'b0
);
    int wc = 0;
    int rc = 0;
    // each side ticks once per own period; the ticks coincide now and then
    always @(posedge sys_clk) begin
        wc <= (wc + 1) % WP;
        rc <= (rc + 1) % RP;
        wclk_en <= (wc == 0);
        rclk_en <= (rc == 0);
    end
endmodule
